// ==== core/mis_defines.svh ====
// Purpose: constants of the interrupt source block
// Assumes: 32-bit wishbone data, byte addresses
// Notes: offsets are word aligned
`ifndef MIS_DEFINES_SVH
`define MIS_DEFINES_SVH

`define MIS_ADR_IRQ_STATUS 8'h00
`define MIS_ADR_TIMER_STATUS 8'h04
`define MIS_ADR_PERIPH_FLAGS 8'h08
`define MIS_ADR_PERIPH_ENABLE 8'h0C
`define MIS_ADR_CPU_STATUS 8'h10
`define MIS_ADR_TIMER_LO 8'h14
`define MIS_ADR_TIMER_HI 8'h18

`define MIS_BIT_EXT_EN 0
`define MIS_BIT_TOV_EN 1
`define MIS_BIT_CKP_EN 2
`define MIS_BIT_PERIPH_EN 3
`define MIS_BIT_EXT_FLAG 4
`define MIS_BIT_TOV_FLAG 5
`define MIS_BIT_CKP_FLAG 6
`define MIS_BIT_PERIPH_FLAG 7
`define MIS_BIT_PIN_POL 7
`define MIS_BIT_TICK_POL 6
`define MIS_BIT_GLOBAL_DIS 4

`define MIS_VEC_RESET 16'h0000
`define MIS_VEC_EXT 16'h0008
`define MIS_VEC_TOV 16'h0010
`define MIS_VEC_CKP 16'h0018
`define MIS_VEC_PERIPH 16'h0020

`define MIS_TIMER_MAX 16'hFFFF
`define MIS_TIMER_ZERO 16'h0000
`define MIS_BYTE_ZERO 8'h00

`endif

// ==== core/mis_pkg.sv ====
// Purpose: types of the interrupt source block
// Assumes: nothing
// Notes: vector selection enumeration
`default_nettype none
package mis_pkg;
    typedef enum logic [2:0] {
        MIS_SRC_NONE,
        MIS_SRC_EXT,
        MIS_SRC_TOV,
        MIS_SRC_CKP,
        MIS_SRC_PERIPH
    } mis_src_e;
endpackage : mis_pkg
`default_nettype wire

// ==== core/mis_edge_detect.sv ====
// Purpose: synchronise a pin and pulse on its chosen edge
// Assumes: pin asynchronous to clk_i
// Notes: pulse is one cycle, independent of any enable
`default_nettype none
module mis_edge_detect (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pin and polarity
    input wire logic pin_i,
    input wire logic rising_i,
    // event
    output logic edge_o
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;
    wire rise_w = sync_reg & ~prev_reg;
    wire fall_w = ~sync_reg & prev_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // one pulse per qualifying edge
    assign edge_o = rising_i ? rise_w : fall_w;
endmodule : mis_edge_detect
`default_nettype wire

// ==== core/mis_vector_stack.sv ====
// Purpose: return address memory for interrupt entry
// Assumes: push and pop never in the same cycle
// Notes: sixteen entries, wraps when overfilled
`default_nettype none
module mis_vector_stack (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // push and pop
    input wire logic push_i,
    input wire logic [15:0] push_data_i,
    input wire logic pop_i,
    // top of stack, registered
    output logic [15:0] top_o
);
    logic [15:0] mem [0:15];
    logic [3:0] ptr_reg;
    wire [3:0] ptr_dec_w = ptr_reg - 4'h1;

    always_ff @(posedge clk_i) begin
        if (push_i) begin
            mem[ptr_reg] <= push_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_reg <= 4'h0;
            top_o <= 16'h0000;
        end else if (push_i) begin
            ptr_reg <= ptr_reg + 4'h1;
            top_o <= push_data_i;
        end else if (pop_i) begin
            ptr_reg <= ptr_dec_w;
            top_o <= mem[ptr_dec_w - 4'h1];
        end
    end
endmodule : mis_vector_stack
`default_nettype wire

// ==== core/mis_interrupt_sources.sv ====
// Purpose: interrupt sources, vectoring and wake of a small cpu
// Assumes: cpu sequencer on the same clock, wishbone classic master
// Notes: ack one cycle after request, unmapped reads give zero
`default_nettype none
`include "mis_defines.svh"

//////////////////////////////////////////////////////////////////////
// Behaviour
// - pin edge chosen by pin polarity bit
// - chosen pin edge sets pin flag
// - pin interrupt blocked when enable clear
// - enabled pin event wakes from sleep
// - timer rollover sets overflow flag
// - overflow interrupt only when enabled
// - tick pin edge chosen by polarity
// - chosen tick edge sets clock flag
// - clock pin interrupt blocked when disabled
// - enabled clock pin event wakes sleep
// - peripheral flag is OR of masked requests
// - masked peripheral requests wake sleep
// - entry pushes only return address
// - four fixed vector addresses loaded
// - reset starts execution at zero
// - priority pin, overflow, clock, peripheral
// - accepting interrupt sets global disable
// - pin and overflow flags cleared on vector
// - global disable set at reset
module mis_interrupt_sources (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // pins
    input wire logic external_event_pin_i,
    input wire logic timer_clock_pin_i,
    // main timer and peripheral requests
    input wire logic timer_tick_i,
    input wire logic [7:0] periph_set_i,
    // cpu sequencer
    input wire logic sleeping_i,
    input wire logic accept_i,
    input wire logic return_i,
    input wire logic [15:0] return_pc_i,
    output logic irq_pending_o,
    output logic wake_o,
    output logic [15:0] vector_o,
    output logic [15:0] return_addr_o,
    output logic global_disable_o
);
    logic [3:0] enable_reg;
    logic ext_pin_flag_reg;
    logic timer_overflow_flag_reg;
    logic clock_pin_flag_reg;
    logic pin_edge_polarity_reg;
    logic tick_pin_edge_polarity_reg;
    logic global_disable_reg;
    logic [7:0] peripheral_request_flags_reg;
    logic [7:0] peripheral_enable_bits_reg;
    logic [15:0] main_timer_reg;
    logic [15:0] vector_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic ext_edge_w;
    logic tick_edge_w;

    ////////////////////////////////////////////////////////////////
    // pin edges
    mis_edge_detect u_ext_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(external_event_pin_i),
        .rising_i(pin_edge_polarity_reg),
        .edge_o(ext_edge_w)
    );
    mis_edge_detect u_tick_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(timer_clock_pin_i),
        .rising_i(tick_pin_edge_polarity_reg),
        .edge_o(tick_edge_w)
    );

    ////////////////////////////////////////////////////////////////
    // bus decode
    wire req_w = cyc_i & stb_i & ~ack_reg;
    wire wr_w = req_w & we_i & sel_i[0];
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit
    wire wr_irq_w = wr_w & hit(adr_i, `MIS_ADR_IRQ_STATUS);
    wire wr_tsta_w = wr_w & hit(adr_i, `MIS_ADR_TIMER_STATUS);
    wire wr_pflag_w = wr_w & hit(adr_i, `MIS_ADR_PERIPH_FLAGS);
    wire wr_pen_w = wr_w & hit(adr_i, `MIS_ADR_PERIPH_ENABLE);
    wire wr_cpu_w = wr_w & hit(adr_i, `MIS_ADR_CPU_STATUS);
    wire wr_tlo_w = wr_w & hit(adr_i, `MIS_ADR_TIMER_LO);
    wire wr_thi_w = wr_w & hit(adr_i, `MIS_ADR_TIMER_HI);

    ////////////////////////////////////////////////////////////////
    // source qualification and priority
    wire combined_peripheral_flag_w =
        |(peripheral_request_flags_reg & peripheral_enable_bits_reg);
    wire ext_req_w = ext_pin_flag_reg & enable_reg[`MIS_BIT_EXT_EN];
    wire tov_req_w = timer_overflow_flag_reg & enable_reg[`MIS_BIT_TOV_EN];
    wire ckp_req_w = clock_pin_flag_reg & enable_reg[`MIS_BIT_CKP_EN];
    wire per_req_w = combined_peripheral_flag_w & enable_reg[`MIS_BIT_PERIPH_EN];
    // a timer write in the same cycle wins over the tick, so no rollover then
    wire rollover_w = timer_tick_i & ~wr_tlo_w & ~wr_thi_w &
        (main_timer_reg == `MIS_TIMER_MAX);
    wire [15:0] timer_inc_w = main_timer_reg + 16'h0001;

    mis_pkg::mis_src_e src_w;
    assign src_w = ext_req_w ? mis_pkg::MIS_SRC_EXT :
                   tov_req_w ? mis_pkg::MIS_SRC_TOV :
                   ckp_req_w ? mis_pkg::MIS_SRC_CKP :
                   per_req_w ? mis_pkg::MIS_SRC_PERIPH : mis_pkg::MIS_SRC_NONE;

    logic [15:0] vec_sel_w;
    always_comb begin
        case (src_w)
            mis_pkg::MIS_SRC_EXT: vec_sel_w = `MIS_VEC_EXT;
            mis_pkg::MIS_SRC_TOV: vec_sel_w = `MIS_VEC_TOV;
            mis_pkg::MIS_SRC_CKP: vec_sel_w = `MIS_VEC_CKP;
            mis_pkg::MIS_SRC_PERIPH: vec_sel_w = `MIS_VEC_PERIPH;
            default: vec_sel_w = `MIS_VEC_RESET;
        endcase
    end

    wire any_req_w = (src_w != mis_pkg::MIS_SRC_NONE);
    wire take_w = accept_i & any_req_w & ~global_disable_reg;
    wire take_ext_w = take_w & (src_w == mis_pkg::MIS_SRC_EXT);
    wire take_tov_w = take_w & (src_w == mis_pkg::MIS_SRC_TOV);

    assign irq_pending_o = any_req_w & ~global_disable_reg;
    // wake ignores global disable, as a sleeping core must resume
    assign wake_o = sleeping_i & any_req_w;
    assign vector_o = vector_reg;
    assign global_disable_o = global_disable_reg;

    ////////////////////////////////////////////////////////////////
    // return address stack
    mis_vector_stack u_stack (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .push_i(take_w),
        .push_data_i(return_pc_i),
        .pop_i(return_i & ~take_w),
        .top_o(return_addr_o)
    );

    ////////////////////////////////////////////////////////////////
    // flags: set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_pin_flag_reg <= 1'b0;
            timer_overflow_flag_reg <= 1'b0;
            clock_pin_flag_reg <= 1'b0;
            peripheral_request_flags_reg <= `MIS_BYTE_ZERO;
        end else begin
            ext_pin_flag_reg <= ext_edge_w |
                (ext_pin_flag_reg & ~take_ext_w &
                 ~(wr_irq_w & ~dat_i[`MIS_BIT_EXT_FLAG]));
            timer_overflow_flag_reg <= rollover_w |
                (timer_overflow_flag_reg & ~take_tov_w &
                 ~(wr_irq_w & ~dat_i[`MIS_BIT_TOV_FLAG]));
            clock_pin_flag_reg <= tick_edge_w |
                (clock_pin_flag_reg & ~(wr_irq_w & ~dat_i[`MIS_BIT_CKP_FLAG]));
            peripheral_request_flags_reg <= periph_set_i |
                (wr_pflag_w ? dat_i[7:0] : peripheral_request_flags_reg);
        end
    end

    ////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_reg <= 4'h0;
            pin_edge_polarity_reg <= 1'b0;
            tick_pin_edge_polarity_reg <= 1'b0;
            peripheral_enable_bits_reg <= `MIS_BYTE_ZERO;
        end else begin
            if (wr_irq_w) begin
                enable_reg <= dat_i[3:0];
            end
            if (wr_tsta_w) begin
                pin_edge_polarity_reg <= dat_i[`MIS_BIT_PIN_POL];
                tick_pin_edge_polarity_reg <= dat_i[`MIS_BIT_TICK_POL];
            end
            if (wr_pen_w) begin
                peripheral_enable_bits_reg <= dat_i[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // global disable, vector and main timer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            global_disable_reg <= 1'b1;
            vector_reg <= `MIS_VEC_RESET;
        end else begin
            if (take_w) begin
                global_disable_reg <= 1'b1;
                vector_reg <= vec_sel_w;
            end else if (return_i) begin
                global_disable_reg <= 1'b0;
            end else if (wr_cpu_w) begin
                global_disable_reg <= dat_i[`MIS_BIT_GLOBAL_DIS];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_timer_reg <= `MIS_TIMER_ZERO;
        end else if (wr_tlo_w) begin
            main_timer_reg <= {main_timer_reg[15:8], dat_i[7:0]};
        end else if (wr_thi_w) begin
            main_timer_reg <= {dat_i[7:0], main_timer_reg[7:0]};
        end else if (timer_tick_i) begin
            main_timer_reg <= timer_inc_w;
        end
    end

    ////////////////////////////////////////////////////////////////
    // read mux and ack
    wire [7:0] irq_status_w = {combined_peripheral_flag_w, clock_pin_flag_reg,
                               timer_overflow_flag_reg, ext_pin_flag_reg, enable_reg};
    always_comb begin
        dat_next = 32'h0000_0000;
        case (adr_i)
            `MIS_ADR_IRQ_STATUS: dat_next[7:0] = irq_status_w;
            `MIS_ADR_TIMER_STATUS: dat_next[7:6] =
                {pin_edge_polarity_reg, tick_pin_edge_polarity_reg};
            `MIS_ADR_PERIPH_FLAGS: dat_next[7:0] = peripheral_request_flags_reg;
            `MIS_ADR_PERIPH_ENABLE: dat_next[7:0] = peripheral_enable_bits_reg;
            `MIS_ADR_CPU_STATUS: dat_next[`MIS_BIT_GLOBAL_DIS] = global_disable_reg;
            `MIS_ADR_TIMER_LO: dat_next[7:0] = main_timer_reg[7:0];
            `MIS_ADR_TIMER_HI: dat_next[7:0] = main_timer_reg[15:8];
            default: dat_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req_w;
            dat_reg <= dat_next;
        end
    end
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    ////////////////////////////////////////////////////////////////
    // checks
    property p_ext_set;
        @(posedge clk_i) disable iff (rst_i) ext_edge_w |=> ext_pin_flag_reg;
    endproperty
    a_ext_set: assert property (p_ext_set) else $error("pin edge lost");
    property p_ext_mask;
        @(posedge clk_i) disable iff (rst_i)
            !enable_reg[`MIS_BIT_EXT_EN] |-> src_w != mis_pkg::MIS_SRC_EXT;
    endproperty
    a_ext_mask: assert property (p_ext_mask) else $error("masked pin taken");
    property p_tov_set;
        @(posedge clk_i) disable iff (rst_i) rollover_w |=> timer_overflow_flag_reg
            && main_timer_reg == `MIS_TIMER_ZERO;
    endproperty
    a_tov_set: assert property (p_tov_set) else $error("rollover missed");
    property p_ckp_set;
        @(posedge clk_i) disable iff (rst_i) tick_edge_w |=> clock_pin_flag_reg;
    endproperty
    a_ckp_set: assert property (p_ckp_set) else $error("tick edge lost");
    property p_take;
        @(posedge clk_i) disable iff (rst_i)
            take_w |=> global_disable_reg && vector_reg == $past(vec_sel_w);
    endproperty
    a_take: assert property (p_take) else $error("entry wrong");
    property p_prio;
        @(posedge clk_i) disable iff (rst_i)
            ext_req_w |-> vec_sel_w == `MIS_VEC_EXT;
    endproperty
    a_prio: assert property (p_prio) else $error("priority wrong");
    property p_gd_block;
        @(posedge clk_i) disable iff (rst_i)
            global_disable_reg |-> !irq_pending_o ##1 $stable(vector_reg);
    endproperty
    a_gd_block: assert property (p_gd_block) else $error("request while disabled");
    property p_ret;
        @(posedge clk_i) disable iff (rst_i)
            return_i && !take_w |=> !global_disable_reg;
    endproperty
    a_ret: assert property (p_ret) else $error("return kept disable");
    property p_wake;
        @(posedge clk_i) disable iff (rst_i)
            sleeping_i && (ext_req_w || ckp_req_w || per_req_w) |-> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_ack;
        @(posedge clk_i) disable iff (rst_i) req_w |=> ack_o ##1 !ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing");
    // entry: pin or overflow flag of the taken source drops unless its own event repeats
    sequence s_take_ext;
        take_ext_w && !ext_edge_w;
    endsequence
    sequence s_take_tov;
        take_tov_w && !rollover_w;
    endsequence
    property p_ext_clear;
        @(posedge clk_i) disable iff (rst_i) s_take_ext |=> !ext_pin_flag_reg;
    endproperty
    a_ext_clear: assert property (p_ext_clear) else $error("pin flag kept");
    property p_tov_clear;
        @(posedge clk_i) disable iff (rst_i) s_take_tov |=> !timer_overflow_flag_reg;
    endproperty
    a_tov_clear: assert property (p_tov_clear) else $error("overflow flag kept");
    property p_push;
        @(posedge clk_i) disable iff (rst_i) take_w |=> return_addr_o == $past(return_pc_i);
    endproperty
    a_push: assert property (p_push) else $error("return address lost");
    property p_reset_state;
        @(posedge clk_i) disable iff (rst_i)
            $fell(rst_i) |-> global_disable_reg && vector_reg == `MIS_VEC_RESET;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
    // a pin held after its edge gives no second event
    sequence s_ext_pulse;
        ext_edge_w ##1 $stable(pin_edge_polarity_reg);
    endsequence
    property p_ext_once;
        @(posedge clk_i) disable iff (rst_i) s_ext_pulse |-> !ext_edge_w;
    endproperty
    a_ext_once: assert property (p_ext_once) else $error("pin edge doubled");
endmodule : mis_interrupt_sources
`default_nettype wire

// ==== dv/mis_cpu_model.sv ====
// Purpose: core sequencer model that takes vectors and returns
// Assumes: same clock as the block
// Notes: waits lat_i pending cycles before taking, returns on request
`default_nettype none
module mis_cpu_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bench control
    input wire logic [3:0] lat_i,
    input wire logic ret_req_i,
    // block side
    input wire logic irq_pending_i,
    output logic accept_o,
    output logic return_o,
    output logic [15:0] pc_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic busy_reg;
    logic [3:0] wait_reg;
    always_ff @(posedge clk_i) begin
        accept_o <= 1'b0;
        return_o <= 1'b0;
        if (rst_i) begin
            busy_reg <= 1'b0;
            wait_reg <= 4'h0;
            pc_o <= 16'h1230;
        end else if (!busy_reg && irq_pending_i) begin
            if (wait_reg >= lat_i) begin
                accept_o <= 1'b1;
                busy_reg <= 1'b1;
                wait_reg <= 4'h0;
            end else begin
                wait_reg <= wait_reg + 4'h1;
            end
        end else if (busy_reg && ret_req_i) begin
            return_o <= 1'b1;
            busy_reg <= 1'b0;
            pc_o <= pc_o + 16'h0011;
        end
    end
endmodule : mis_cpu_model
`default_nettype wire

// ==== dv/tb_mcu_interrupt_sources.sv ====
// Purpose: self-checking bench of the interrupt source block
// Assumes: ack one cycle after a taken request
// Notes: bench model keeps flags as bits, vectors in a table
`default_nettype none
module tb_mcu_interrupt_sources;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00, periph_set_i = 8'h00;
    logic [3:0] sel_i = 4'h0, lat = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rnd = 32'h1F;
    logic ack_o, ext_pin = 1'b0, tick_pin = 1'b0, timer_tick_i = 1'b0, sleeping_i = 1'b0;
    logic accept_i, return_i, ret_req = 1'b0, irq_pending_o, wake_o, global_disable_o;
    logic [15:0] return_pc_i, vector_o, return_addr_o, pc;
    logic [3:0] m;
    logic [15:0] stk [$];
    logic [15:0] vecs [4] = '{16'h0008, 16'h0010, 16'h0018, 16'h0020};
    int bad_count = 0, checks = 0, n;

    mis_interrupt_sources u_mis_interrupt_sources (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .external_event_pin_i(ext_pin),
        .timer_clock_pin_i(tick_pin), .timer_tick_i(timer_tick_i),
        .periph_set_i(periph_set_i), .sleeping_i(sleeping_i), .accept_i(accept_i),
        .return_i(return_i), .return_pc_i(return_pc_i), .irq_pending_o(irq_pending_o),
        .wake_o(wake_o), .vector_o(vector_o), .return_addr_o(return_addr_o),
        .global_disable_o(global_disable_o));
    mis_cpu_model u_mis_cpu_model (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat),
        .ret_req_i(ret_req), .irq_pending_i(irq_pending_o), .accept_o(accept_i),
        .return_o(return_i), .pc_o(return_pc_i));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        if (n >= 50) chk("bus ack", 32'h1, 32'h0);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] mk, input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk($sformatf("reg %0h", a), {24'h0, e}, q & {24'h0, mk});
    endtask : rdc

    task automatic pin(input int p, input logic v);
        @(posedge clk_i);
        if (p == 0) ext_pin <= v;
        else tick_pin <= v;
        repeat (5) @(posedge clk_i);
    endtask : pin

    task automatic tick();
        @(posedge clk_i);
        timer_tick_i <= 1'b1;
        @(posedge clk_i);
        timer_tick_i <= 1'b0;
    endtask : tick

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk("vector", 32'h0, vector_o);
        chk("global disable", 32'h1, global_disable_o);
        rdc(8'h00, 8'hFF, 8'h00);
        rdc(8'h10, 8'h10, 8'h10);
        rdc(8'h3C, 8'hFF, 8'h00);
        // wrong edge ignored, right edge flags once, enables off
        for (int p = 0; p < 2; p++) begin
            for (int pl = 0; pl < 2; pl++) begin
                pin(p, pl[0]);
                wr(8'h04, {24'h0, pl[0], pl[0], 6'h0});
                wr(8'h00, 32'h0);
                pin(p, !pl[0]);
                rdc(8'h00, 8'h7F, 8'h00);
                pin(p, pl[0]);
                rdc(8'h00, 8'h7F, p ? 8'h40 : 8'h10);
                wr(8'h00, 32'h0);
                repeat (5) @(posedge clk_i);
                rdc(8'h00, 8'h7F, 8'h00);
            end
        end
        wr(8'h14, 32'hFE);
        wr(8'h18, 32'hFF);
        tick();
        rdc(8'h00, 8'h7F, 8'h00);
        tick();
        rdc(8'h00, 8'h7F, 8'h20);
        for (int i = 0; i < 6; i++) begin
            rnd = xs(rnd);
            wr(8'h08, {24'h0, rnd[7:0]});
            wr(8'h0C, {24'h0, rnd[15:8]});
            @(posedge clk_i);
            periph_set_i <= rnd[23:16];
            @(posedge clk_i);
            periph_set_i <= 8'h00;
            rdc(8'h08, 8'hFF, rnd[7:0] | rnd[23:16]);
            rdc(8'h00, 8'h80, |((rnd[7:0] | rnd[23:16]) & rnd[15:8]) ? 8'h80 : 8'h00);
        end
        // all four sources pending together
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0);
        pin(0, 1'b0);
        pin(1, 1'b0);
        wr(8'h14, 32'hFF);
        wr(8'h18, 32'hFF);
        tick();
        wr(8'h08, 32'h01);
        wr(8'h0C, 32'h01);
        rdc(8'h00, 8'hFF, 8'hF0);
        sleeping_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 32'h70 | (32'h1 << i));
            @(negedge clk_i);
            chk("wake", 32'h1, wake_o);
            chk("pending", 32'h0, irq_pending_o);
        end
        wr(8'h00, 32'h70);
        @(negedge clk_i);
        chk("wake", 32'h0, wake_o);
        @(posedge clk_i);
        sleeping_i <= 1'b0;
        wr(8'h10, 32'h0);
        @(negedge clk_i);
        chk("pending", 32'h0, irq_pending_o);
        m = 4'hF;
        for (int k = 0; k < 4; k++) begin
            if (k == 0) wr(8'h00, 32'h7F);
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (accept_i !== 1'b1 && n < 100);
            if (n >= 100) chk("accept", 32'h1, 32'h0);
            pc = return_pc_i;
            @(negedge clk_i);
            chk("vector", {16'h0, vecs[k]}, vector_o);
            chk("global disable", 32'h1, global_disable_o);
            stk.push_back(pc);
            chk("return address", {16'h0, stk[$]}, return_addr_o);
            if (k < 2) m[k] = 1'b0;
            rdc(8'h00, 8'hFF, {m[3], m[2], m[1], m[0], 4'hF});
            if (k == 2) wr(8'h00, 32'h0F);
            if (k == 3) wr(8'h08, 32'h0);
            m[k] = 1'b0;
            @(posedge clk_i);
            ret_req <= 1'b1;
            lat <= 4'h3;
            @(posedge clk_i);
            ret_req <= 1'b0;
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (return_i !== 1'b1 && n < 20);
            if (n >= 20) chk("return", 32'h1, 32'h0);
            @(negedge clk_i);
            chk("global disable", 32'h0, global_disable_o);
            void'(stk.pop_back());
        end
        wr(8'h10, 32'h10);
        rdc(8'h10, 8'h10, 8'h10);
        print_verdict();
    end
endmodule : tb_mcu_interrupt_sources
`default_nettype wire
